// ===== design/ser_params.svh
`ifndef SER_PARAMS_SVH
`define SER_PARAMS_SVH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define SER_ADDR_LOG_LO   40'h80_0000_3008
`define SER_ADDR_LOG_HI   40'h80_0000_300C
`define SER_ADDR_TRAP_LO  40'h80_0000_3010
`define SER_ADDR_TRAP_HI  40'h80_0000_3014
`define SER_ADDR_STAT     40'h80_0000_3018

// ----------------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------------
`define SER_LOG_RESET     64'h0000_07FF_FFFF_FFFF
`define SER_LOG_WMASK     64'hFFFF_FFFF_C7FF_FFAA
`define SER_TRAP_RESET    64'h0000_0000_0000_0000
`define SER_TRAP_WMASK    64'h7FFF_FFFF_C7FF_FFAA

// ----------------------------------------------------------------------------
// source layout
// ----------------------------------------------------------------------------
`define SER_SRC_MASK      64'h0000_076D_86FF_FFAA
`define SER_CE_MASK       64'h0000_036D_8480_0408
`define SER_SW_TRAP_BIT   24
`define SER_DMU_CREDIT    42
`define SER_STAT_BUSY     0
`define SER_STAT_PEND     1

// ----------------------------------------------------------------------------
// packet error codes
// ----------------------------------------------------------------------------
`define SER_ERR_CE        2'h1
`define SER_ERR_UE        2'h2

`endif

// ===== design/ser_pkg.sv
package ser_pkg;
  // packet sender states
  typedef enum logic {
    SER_IDLE,
    SER_SEND
  } ser_state_e;

  typedef logic [63:0] ser_word_t;

  // error-indication packet contents
  typedef struct packed {
    logic [1:0] err;
    logic [5:0] src;
  } ser_pkt_s;
endpackage

// ===== design/ser_reg_if.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// write port and contents of one 64-bit enable bank
// ----------------------------------------------------------------------------
interface ser_reg_if;
  logic             wr_lo;
  logic             wr_hi;
  logic [31:0]      wdata;
  ser_pkg::ser_word_t q;

  modport bank (input wr_lo, input wr_hi, input wdata, output q);
  modport ctrl (output wr_lo, output wr_hi, output wdata, input q);
endinterface

// ===== design/ser_enreg.sv
`timescale 1ns/1ns
`include "ser_params.svh"
// ----------------------------------------------------------------------------
// 64-bit enable bank written as two 32-bit halves
// ----------------------------------------------------------------------------
module ser_enreg #(
  parameter logic [63:0] RESET = 64'h0000_0000_0000_0000,
  parameter logic [63:0] WMASK = 64'hFFFF_FFFF_FFFF_FFFF
) (
  input wire logic    mclk,
  input wire logic    nrst,
  ser_reg_if.bank     rif
);
  ser_pkg::ser_word_t q_reg;
  ser_pkg::ser_word_t q_next;
  wire logic [63:0]   wr_vec;
  wire logic [63:0]   wr_en;

  // lane select: writable bits of the addressed half take new data
  assign wr_vec = {rif.wdata, rif.wdata};
  assign wr_en  = WMASK & {{32{rif.wr_hi}}, {32{rif.wr_lo}}};
  assign q_next = (q_reg & ~wr_en) | (wr_vec & wr_en);
  assign rif.q  = q_reg;

  // storage, fixed bits keep their reset value
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      q_reg <= RESET;
    end else begin
      q_reg <= q_next;
    end
  end

  property p_fixed_bits;
    @(posedge mclk) disable iff (!nrst)
    ((q_reg & ~WMASK) == (RESET & ~WMASK));
  endproperty
  a_fixed_bits: assert property (p_fixed_bits)
    else $error("fixed enable bits changed");

  property p_spare_write;
    @(posedge mclk) disable iff (!nrst)
    rif.wr_hi |=> ((q_reg[63:32] & WMASK[63:32]) == ($past(rif.wdata) & WMASK[63:32]));
  endproperty
  a_spare_write: assert property (p_spare_write)
    else $error("spare enable bits not stored");
endmodule

// ===== design/ser_pick.sv
`timescale 1ns/1ns
`include "ser_params.svh"
// ----------------------------------------------------------------------------
// lowest pending source and its class
// ----------------------------------------------------------------------------
module ser_pick (
  input  wire logic [63:0] pend,
  output logic             found,
  output logic [5:0]       src,
  output logic             is_ce
);
  localparam logic [63:0] CE_MASK = `SER_CE_MASK;

  // scan from the top so the lowest set bit wins
  always_comb begin
    found = 1'b0;
    src   = 6'h00;
    for (int i = 63; i >= 0; i--) begin
      if (pend[i]) begin
        found = 1'b1;
        src   = 6'(i);
      end
    end
    is_ce = CE_MASK[src];
  end
endmodule

// ===== design/ser_top.sv
// Contract
// - log enable bit 1 lets its source reach the error status register
// - log enable resets to zero above bit 42, ones at 42 and below
// - bit 42 covers the credit token bus parity error
// - memory controller pairs at 32/31 to 41/40, threshold high, link low
// - bits 26 and 25 cover corrected and uncorrected old fifo tag errors
// - bits 23 to 14 cover the non-cacheable unit sources
// - bits 13 to 8 cover the DMA unit sources
// - odd bits 7 to 1 cover interface errors, even bits reserved
// - spare bits are plain storage with no source attached
// - a software write of bit 24 raises a trap request
// - trap enable bits 62 to 0 reset to zero and select packets
// - an enabled error always sends its indication packet; the code sends one only when its log and trap enable bits are both set
// - correctable errors carry code 01
// - uncorrectable errors carry code 10
// - spare trap enable bits are writable
// - no trap request while the pending valid bit is set
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`include "ser_params.svh"
module ser_top #(
  parameter int ADDR_W = 40
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [63:0]       err_event,
  input  wire logic              pending_valid,
  input  wire logic              pkt_ready,
  output logic [63:0]            log_strobe,
  output logic                   pkt_valid,
  output logic [1:0]             pkt_err,
  output logic [5:0]             pkt_src,
  output logic                   trap_req
);
  localparam logic [63:0] SRC_MASK = `SER_SRC_MASK;
  localparam logic [63:0] CE_MASK  = `SER_CE_MASK;

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  logic [31:0]            prdata_reg;
  logic                   pready_reg;
  logic                   pslverr_reg;
  logic [63:0]            log_strobe_reg;
  logic [63:0]            pend_reg;
  logic [63:0]            pend_next;
  ser_pkg::ser_state_e    state_reg;
  ser_pkg::ser_state_e    state_next;
  ser_pkg::ser_pkt_s      pkt_reg;
  logic                   trap_req_reg;
  logic                   pkt_valid_reg;
  wire logic              acc;
  wire logic              wr_fire;
  wire logic              sel_log_lo;
  wire logic              sel_log_hi;
  wire logic              sel_trap_lo;
  wire logic              sel_trap_hi;
  wire logic              sel_stat;
  wire logic              mapped;
  wire logic [31:0]       rdata;
  wire logic [31:0]       stat_word;
  wire logic [63:0]       logged;
  wire logic [63:0]       sw_vec;
  wire logic [63:0]       set_vec;
  wire logic [63:0]       clr_vec;
  wire logic              sw_trap;
  wire logic              launch;
  wire logic              done;
  wire logic              pick_found;
  wire logic [5:0]        pick_src;
  wire logic              pick_ce;
  wire logic [63:0]       log_q;
  wire logic [63:0]       trap_q;

  ser_reg_if log_if ();
  ser_reg_if trap_if ();

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  // one wait state: data is ready on the second access cycle
  assign acc         = psel & penable;
  assign wr_fire     = acc & pready_reg & pwrite;
  assign sel_log_lo  = (paddr == ADDR_W'(`SER_ADDR_LOG_LO));
  assign sel_log_hi  = (paddr == ADDR_W'(`SER_ADDR_LOG_HI));
  assign sel_trap_lo = (paddr == ADDR_W'(`SER_ADDR_TRAP_LO));
  assign sel_trap_hi = (paddr == ADDR_W'(`SER_ADDR_TRAP_HI));
  assign sel_stat    = (paddr == ADDR_W'(`SER_ADDR_STAT));
  assign mapped      = sel_log_lo | sel_log_hi | sel_trap_lo | sel_trap_hi | sel_stat;

  // bank write strobes
  assign log_if.wr_lo  = wr_fire & sel_log_lo;
  assign log_if.wr_hi  = wr_fire & sel_log_hi;
  assign log_if.wdata  = pwdata;
  assign trap_if.wr_lo = wr_fire & sel_trap_lo;
  assign trap_if.wr_hi = wr_fire & sel_trap_hi;
  assign trap_if.wdata = pwdata;
  assign log_q         = log_if.q;
  assign trap_q        = trap_if.q;

  // read mux, unmapped reads return zero
  assign stat_word = {30'h0000_0000, (pend_reg != 64'h0), (state_reg == ser_pkg::SER_SEND)};
  assign rdata = sel_log_lo  ? log_q[31:0]  :
                 sel_log_hi  ? log_q[63:32] :
                 sel_trap_lo ? trap_q[31:0] :
                 sel_trap_hi ? trap_q[63:32] :
                 sel_stat    ? stat_word    : 32'h0000_0000;

  // apb answer registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= acc & ~pready_reg;
      pslverr_reg <= acc & ~pready_reg & ~mapped;
      if (acc & ~pready_reg) begin
        prdata_reg <= rdata;
      end
    end
  end

  // --------------------------------------------------------------------------
  // enable banks
  // --------------------------------------------------------------------------
  // log bank: reserved positions stay at one
  ser_enreg #(
    .RESET (`SER_LOG_RESET),
    .WMASK (`SER_LOG_WMASK)
  ) u_log (
    .mclk  (mclk),
    .nrst  (nrst),
    .rif   (log_if)
  );

  // trap bank: bit 63 and reserved positions read zero, spares writable
  ser_enreg #(
    .RESET (`SER_TRAP_RESET),
    .WMASK (`SER_TRAP_WMASK)
  ) u_trap (
    .mclk  (mclk),
    .nrst  (nrst),
    .rif   (trap_if)
  );

  // --------------------------------------------------------------------------
  // error intake
  // --------------------------------------------------------------------------
  // only implemented sources are logged; spares, reserved and bit 24 never
  assign logged  = err_event & log_q & SRC_MASK;
  assign sw_trap = log_if.wr_lo & pwdata[`SER_SW_TRAP_BIT];
  assign sw_vec  = {39'h0, sw_trap & trap_q[`SER_SW_TRAP_BIT], 24'h00_0000};
  assign set_vec = (logged & trap_q) | sw_vec;

  // strobes toward the error status register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      log_strobe_reg <= 64'h0;
    end else begin
      log_strobe_reg <= logged;
    end
  end

  // --------------------------------------------------------------------------
  // packet sender
  // --------------------------------------------------------------------------
  ser_pick u_pick (
    .pend  (pend_reg),
    .found (pick_found),
    .src   (pick_src),
    .is_ce (pick_ce)
  );

  // a newly arriving event beats the clear of the same bit
  assign launch    = (state_reg == ser_pkg::SER_IDLE) & pick_found;
  assign done      = (state_reg == ser_pkg::SER_SEND) & pkt_ready;
  assign clr_vec   = launch ? (64'h1 << pick_src) : 64'h0;
  assign pend_next = (pend_reg & ~clr_vec) | set_vec;

  // next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ser_pkg::SER_IDLE: begin
        if (launch) begin
          state_next = ser_pkg::SER_SEND;
        end
      end
      ser_pkg::SER_SEND: begin
        if (done) begin
          state_next = ser_pkg::SER_IDLE;
        end
      end
    endcase
  end

  // state, pending set and packet fields
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ser_pkg::SER_IDLE;
      pend_reg  <= 64'h0;
      pkt_reg   <= '0;
      pkt_valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // packet valid follows the sender state straight from a flop
      pkt_valid_reg <= (state_next == ser_pkg::SER_SEND);
      pend_reg  <= pend_next;
      if (launch) begin
        pkt_reg.src <= pick_src;
        pkt_reg.err <= pick_ce ? `SER_ERR_CE : `SER_ERR_UE;
      end
    end
  end

  // trap pulse at launch unless a pending error is still held
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      trap_req_reg <= 1'b0;
    end else begin
      trap_req_reg <= launch & ~pending_valid;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign log_strobe = log_strobe_reg;
  assign pkt_valid  = pkt_valid_reg;
  assign pkt_err    = pkt_reg.err;
  assign pkt_src    = pkt_reg.src;
  assign trap_req   = trap_req_reg;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  property p_log_gate;
    @(posedge mclk) disable iff (!nrst)
    ##1 (log_strobe == ($past(err_event) & $past(log_q) & SRC_MASK));
  endproperty
  a_log_gate: assert property (p_log_gate)
    else $error("log strobe does not follow enabled events");

  property p_log_reset;
    @(posedge mclk)
    $rose(nrst) |-> (log_q == 64'h0000_07FF_FFFF_FFFF);
  endproperty
  a_log_reset: assert property (p_log_reset)
    else $error("log enable reset value wrong");

  property p_credit_bit;
    @(posedge mclk) disable iff (!nrst)
    (err_event[42] && log_q[42]) |=> log_strobe[42];
  endproperty
  a_credit_bit: assert property (p_credit_bit)
    else $error("credit parity error not logged");

  property p_memctl_class;
    @(posedge mclk) disable iff (!nrst)
    (pkt_valid && (pkt_src inside {6'h1F, 6'h20, 6'h28, 6'h29})) |-> (pkt_err == 2'h1);
  endproperty
  a_memctl_class: assert property (p_memctl_class)
    else $error("memory controller error not correctable");

  property p_no_spare_log;
    @(posedge mclk) disable iff (!nrst)
    ##1 (log_strobe[24] == 1'b0) && (log_strobe[39] == 1'b0) && (log_strobe[0] == 1'b0);
  endproperty
  a_no_spare_log: assert property (p_no_spare_log)
    else $error("spare or reserved bit logged");

  property p_sw_trap;
    @(posedge mclk) disable iff (!nrst)
    (sw_trap && trap_q[24]) |=> pend_reg[24] || (pkt_valid && pkt_src == 6'h18);
  endproperty
  a_sw_trap: assert property (p_sw_trap)
    else $error("software write of bit 24 raised no request");

  property p_trap_reset;
    @(posedge mclk)
    $rose(nrst) |-> (trap_q == 64'h0) && !pkt_valid && !trap_req;
  endproperty
  a_trap_reset: assert property (p_trap_reset)
    else $error("trap enable not zero after reset");

  property p_pkt_hold;
    @(posedge mclk) disable iff (!nrst)
    (pkt_valid && !pkt_ready) |=> pkt_valid && $stable(pkt_src) && $stable(pkt_err);
  endproperty
  a_pkt_hold: assert property (p_pkt_hold)
    else $error("packet dropped before acceptance");

  property p_err_code;
    @(posedge mclk) disable iff (!nrst)
    pkt_valid |-> (pkt_err == (CE_MASK[pkt_src] ? 2'h1 : 2'h2));
  endproperty
  a_err_code: assert property (p_err_code)
    else $error("packet error code does not match class");

  property p_ue_code;
    @(posedge mclk) disable iff (!nrst)
    (pkt_valid && pkt_src == 6'h2A) |-> (pkt_err == 2'h2);
  endproperty
  a_ue_code: assert property (p_ue_code)
    else $error("uncorrectable error code wrong");

  property p_suppress;
    @(posedge mclk) disable iff (!nrst)
    trap_req |-> !$past(pending_valid) && $past(launch);
  endproperty
  a_suppress: assert property (p_suppress)
    else $error("trap request while pending valid");

  property p_both_enables;
    @(posedge mclk) disable iff (!nrst)
    (err_event[13] && !(log_q[13] && trap_q[13]) && !pend_reg[13]) |=> !pend_reg[13];
  endproperty
  a_both_enables: assert property (p_both_enables)
    else $error("event queued without both enables");

  property p_apb_wait;
    @(posedge mclk) disable iff (!nrst)
    (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("apb answer not after one wait state");

  // spare trap enables in the upper half keep what software wrote
  property p_trap_spare;
    @(posedge mclk) disable iff (!nrst)
    trap_if.wr_hi |=> ((trap_q[63:32] & 32'h7FFF_FFFF) == ($past(pwdata) & 32'h7FFF_FFFF));
  endproperty
  a_trap_spare: assert property (p_trap_spare)
    else $error("spare trap enable bits not stored");
endmodule

// ===== testbench/ser_xbar_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// crossbar side: takes each packet after a settable number of stall cycles
// ----------------------------------------------------------------------------
module ser_xbar_model (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       pkt_valid,
  input  wire logic [3:0] stall,
  output logic            pkt_ready
);
  logic [3:0] wait_cnt;

  // ready rises once a waiting packet has stalled long enough, drops after the accept edge
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pkt_ready <= 1'b0;
      wait_cnt  <= 4'h0;
    end else if (pkt_ready && pkt_valid) begin
      pkt_ready <= 1'b0;
      wait_cnt  <= 4'h0;
    end else if (pkt_valid && wait_cnt >= stall) begin
      pkt_ready <= 1'b1;
    end else if (pkt_valid) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

// ===== testbench/ser_top_bench.sv
`timescale 1ns/1ns
`include "ser_params.svh"
module ser_top_bench;
  logic        mclk;
  logic        nrst;
  logic [39:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [63:0] err_event;
  logic        pending_valid;
  logic        pkt_ready;
  logic [63:0] log_strobe;
  logic        pkt_valid;
  logic [1:0]  pkt_err;
  logic [5:0]  pkt_src;
  logic        trap_req;
  logic [3:0]  stall;
  logic [31:0] rd;
  logic        err;
  int          error_cnt;
  int          n_checks;

  // correctable sources, plus sources that log and sources that never do
  localparam logic [63:0] CE_SRC = 64'h0000_036D_8480_0408;
  localparam int SRCS [15] = '{42, 41, 40, 32, 31, 26, 25, 23, 14, 13, 12, 10, 8, 7, 1};
  localparam int NOSRC [4] = '{30, 24, 50, 4};

  ser_top u_ser_top (.mclk(mclk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .err_event(err_event),
    .pending_valid(pending_valid), .pkt_ready(pkt_ready), .log_strobe(log_strobe),
    .pkt_valid(pkt_valid), .pkt_err(pkt_err), .pkt_src(pkt_src), .trap_req(trap_req));

  ser_xbar_model u_ser_xbar_model (.mclk(mclk), .nrst(nrst), .pkt_valid(pkt_valid),
    .stall(stall), .pkt_ready(pkt_ready));

  // ----------------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [39:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    chk("apb answer", 1, pready);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [39:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, {1'b0, exp}, {err, rd});
  endtask

  // one-cycle event pulse, then the log strobe one cycle later
  task automatic pulse(input logic [63:0] m, input logic [63:0] exp);
    @(posedge mclk);
    err_event <= m;
    @(posedge mclk);
    err_event <= 64'h0;
    @(posedge mclk);
    chk("log_strobe", exp, log_strobe);
  endtask

  // wait for a packet, check its fields and trap, then wait for acceptance
  task automatic pkt(input logic [5:0] src, input logic [1:0] code, input logic trap);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pkt_valid !== 1'b1 && n < 20);
    chk("packet", {1'b1, code, src, trap}, {pkt_valid, pkt_err, pkt_src, trap_req});
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!(pkt_valid === 1'b1 && pkt_ready === 1'b1) && n < 20);
    chk("accept", 1, pkt_valid & pkt_ready);
  endtask

  task automatic nopkt();
    repeat (8) begin
      @(posedge mclk);
      chk("no packet", 0, {pkt_valid, trap_req});
    end
  endtask

  // ----------------------------------------------------------------------------
  // clock, watchdog and test sequence
  // ----------------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // cuts a hang short after far more than the sequence needs
  initial begin
    #400000;
    error_cnt++;
    results();
  end

  initial begin
    nrst = 1'b0;
    paddr = 40'h00_0000_0000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0000_0000;
    err_event = 64'h0;
    pending_valid = 1'b0;
    stall = 4'h0;
    error_cnt = 0;
    n_checks = 0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    rchk("log lo reset", `SER_ADDR_LOG_LO, 32'hFFFF_FFFF);
    rchk("log hi reset", `SER_ADDR_LOG_HI, 32'h0000_07FF);
    rchk("trap lo reset", `SER_ADDR_TRAP_LO, 32'h0000_0000);
    rchk("trap hi reset", `SER_ADDR_TRAP_HI, 32'h0000_0000);
    apb(1'b1, `SER_ADDR_LOG_LO, 32'h0000_0000);
    rchk("log lo fixed", `SER_ADDR_LOG_LO, 32'h3800_0055);
    apb(1'b1, `SER_ADDR_LOG_HI, 32'hFFFF_FFFF);
    rchk("log hi spare", `SER_ADDR_LOG_HI, 32'hFFFF_FFFF);
    apb(1'b1, `SER_ADDR_LOG_HI, 32'h0000_07FF);
    apb(1'b1, `SER_ADDR_LOG_LO, 32'hFEFF_FFFF);
    apb(1'b1, `SER_ADDR_TRAP_HI, 32'hFFFF_FFFF);
    rchk("trap hi spare", `SER_ADDR_TRAP_HI, 32'h7FFF_FFFF);
    apb(1'b1, `SER_ADDR_TRAP_LO, 32'hFFFF_FFFF);
    rchk("trap lo", `SER_ADDR_TRAP_LO, 32'hC7FF_FFAA);
    apb(1'b1, 40'h80_0000_3020, 32'hFFFF_FFFF);
    chk("unmapped write", 1, err);
    apb(1'b0, 40'h80_0000_3020, 32'h0000_0000);
    chk("unmapped read", {1'b1, 32'h0}, {err, rd});
    // fifteen of the implemented sources, bit 42 down to bit 1, each log and send a packet with its class
    for (int i = 0; i < 15; i++) begin
      pulse(64'h1 << SRCS[i], 64'h1 << SRCS[i]);
      pkt(6'(SRCS[i]), CE_SRC[SRCS[i]] ? 2'h1 : 2'h2, 1'b1);
    end
    // spare, software-only and reserved positions have no source
    for (int i = 0; i < 4; i++) begin
      pulse(64'h1 << NOSRC[i], 64'h0);
      nopkt();
    end
    apb(1'b1, `SER_ADDR_LOG_LO, 32'hFFFF_FFFF);
    pkt(6'h18, 2'h2, 1'b1);
    apb(1'b1, `SER_ADDR_LOG_LO, 32'hFEFF_DFFF);
    pulse(64'h1 << 13, 64'h0);
    nopkt();
    apb(1'b1, `SER_ADDR_TRAP_LO, 32'hFFFF_FBFF);
    pulse(64'h1 << 10, 64'h1 << 10);
    nopkt();
    pending_valid <= 1'b1;
    pulse(64'h1 << 8, 64'h1 << 8);
    pkt(6'h08, 2'h2, 1'b0);
    pending_valid <= 1'b0;
    // two at once with a stalling crossbar: lowest source goes first
    stall <= 4'h3;
    pulse(64'h0000_0000_0000_0880, 64'h0000_0000_0000_0880);
    pkt(6'h07, 2'h2, 1'b1);
    pkt(6'h0B, 2'h2, 1'b1);
    nopkt();
    // status word is read-only and idle once every packet is gone
    apb(1'b1, `SER_ADDR_STAT, 32'hFFFF_FFFF);
    chk("stat write", 0, err);
    rchk("stat idle", `SER_ADDR_STAT, 32'h0000_0000);
    results();
  end
endmodule
